// [rtl/frac_pll_reconfig_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "frac_pll_reconfig_defines.svh"
module frac_pll_reconfig_regs
(
  input  wire logic                               clk_in,
  input  wire logic                               rst_b_in,
  input  wire logic [5:0]                         mgmt_address_in,
  input  wire logic                               mgmt_read_in,
  input  wire logic                               mgmt_write_in,
  input  wire logic [31:0]                        mgmt_write_data_in,
  output var  logic [31:0]                        mgmt_read_data_out,
  output var  logic                               mgmt_waitrequest_out,
  output var  frac_pll_reconfig_pkg::pll_setup_t  pll_setup_out,
  output var  logic [18*18-1:0]                   out_dividers_out,
  output var  frac_pll_reconfig_pkg::phase_step_t phase_step_out,
  output var  logic                               apply_strobe_out,
  output var  logic                               phase_strobe_out
);
  frac_pll_reconfig_pkg::pll_setup_t   stage_q;
  frac_pll_reconfig_pkg::divider_t     out_div_q [`NUM_OUT_DIV];
  frac_pll_reconfig_pkg::phase_step_t  phase_q;
  frac_pll_reconfig_pkg::apply_state_t state_q;
  logic                                style_q;
  logic                                phase_pend_q;
  logic [3:0]                          cnt_q;
  logic [31:0]                         rdata_d;
  logic                                wait_d;

  // Commands only taken while wait-request is low
  wire logic accept_wr = mgmt_write_in && !mgmt_waitrequest_out;  // see RL20 see RL21
  wire logic accept_rd = mgmt_read_in && !mgmt_waitrequest_out;   // see RL21
  wire logic busy      = state_q != frac_pll_reconfig_pkg::IDLE;
  wire logic wr_style  = accept_wr && mgmt_address_in == `ADR_STYLE;
  wire logic wr_apply  = accept_wr && mgmt_address_in == `ADR_APPLY;
  wire logic wr_pre    = accept_wr && mgmt_address_in == `ADR_PRESCALE;
  wire logic wr_fb     = accept_wr && mgmt_address_in == `ADR_FEEDBACK;
  wire logic wr_out    = accept_wr && mgmt_address_in == `ADR_OUTPUT;
  wire logic wr_phase  = accept_wr && mgmt_address_in == `ADR_PHASE;
  wire logic wr_frac   = accept_wr && mgmt_address_in == `ADR_FRACTION;
  wire logic wr_bw     = accept_wr && mgmt_address_in == `ADR_BANDWIDTH;
  wire logic wr_pump   = accept_wr && mgmt_address_in == `ADR_PUMP;
  wire logic wr_halv   = accept_wr && mgmt_address_in == `ADR_HALVING;
  wire logic wr_prof   = accept_wr && mgmt_address_in == `ADR_PROFILE;
  wire logic [4:0] out_sel = mgmt_write_data_in[22:18];               // see RL9
  wire logic out_sel_ok    = out_sel <= `OUT_IDX_MAX;                 // see RL9
  wire logic in_out_rd = mgmt_address_in >= `ADR_OUT_FIRST && mgmt_address_in <= `ADR_OUT_LAST;
  wire logic [5:0] out_rd_idx = mgmt_address_in - `ADR_OUT_FIRST;     // see RL23
  // Waitrequest mode holds off the master during a reconfiguration
  wire logic hold_off = !style_q && (busy || wr_apply);               // see RL1
  wire frac_pll_reconfig_pkg::divider_t div_in = mgmt_write_data_in[17:0]; // see RL4 see RL6

  always_comb
  begin
    rdata_d = 32'h00000000;
    wait_d  = hold_off;
    if (accept_rd)
    begin
      unique case (1'b1)
        mgmt_address_in == `ADR_STYLE:     rdata_d = {31'h00000000, style_q};             // see RL1
        mgmt_address_in == `ADR_READY:     rdata_d = {31'h00000000, !busy};               // see RL2
        mgmt_address_in == `ADR_PRESCALE:  rdata_d = {16'h0000, stage_q.prescale[15:0]};  // see RL10
        mgmt_address_in == `ADR_FEEDBACK:  rdata_d = {16'h0000, stage_q.feedback[15:0]};  // see RL10
        mgmt_address_in == `ADR_BANDWIDTH: rdata_d = {28'h0000000, stage_q.loop_bandwidth_code}; // see RL17
        mgmt_address_in == `ADR_PUMP:      rdata_d = {29'h00000000, stage_q.pump_current_code};  // see RL17
        mgmt_address_in == `ADR_HALVING:   rdata_d = {31'h00000000, stage_q.osc_halving_select}; // see RL18
        in_out_rd:                         rdata_d = {16'h0000, out_div_q[out_rd_idx[4:0]][15:0]}; // see RL11 see RL23
        default:                           rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mgmt_read_data_out   <= 32'h00000000;
      mgmt_waitrequest_out <= 1'b0;
      style_q              <= 1'b0;
    end
    else
    begin
      mgmt_read_data_out   <= rdata_d;
      mgmt_waitrequest_out <= wait_d;                    // see RL21
      if (wr_style)
        style_q <= mgmt_write_data_in[0];                // see RL1
    end
  end

  // Staged settings, reset to initial values
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      stage_q.prescale              <= `DIV_RESET;      // see RL22
      stage_q.feedback              <= `DIV_RESET;
      stage_q.feedback_fraction     <= `FRAC_RESET;
      stage_q.loop_bandwidth_code   <= 4'h0;
      stage_q.pump_current_code     <= 3'h0;
      stage_q.osc_halving_select    <= 1'b0;
      stage_q.profile_base_location <= 9'h000;
      phase_q                       <= '0;
    end
    else
    begin
      if (wr_pre)
        stage_q.prescale <= div_in;                      // see RL5 see RL6
      if (wr_fb)
        stage_q.feedback <= div_in;                      // see RL7 see RL16
      if (wr_frac)
        stage_q.feedback_fraction <= mgmt_write_data_in; // see RL15 see RL16
      if (wr_bw)
        stage_q.loop_bandwidth_code <= mgmt_write_data_in[3:0];   // see RL17
      if (wr_pump)
        stage_q.pump_current_code <= mgmt_write_data_in[2:0];     // see RL17
      if (wr_halv)
        stage_q.osc_halving_select <= mgmt_write_data_in[0];      // see RL18
      if (wr_prof)
        stage_q.profile_base_location <= mgmt_write_data_in[8:0]; // see RL19
      if (wr_phase)
        phase_q <= mgmt_write_data_in[21:0];             // see RL12 see RL13 see RL14
    end
  end

  // Output divider bank, one entry per divider
  genvar g;
  generate
    for (g = 0; g < `NUM_OUT_DIV; g = g + 1)
    begin : g_out
      always_ff @(posedge clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
          out_div_q[g] <= `DIV_RESET;
        else if (wr_out && out_sel_ok && out_sel == 5'(g))
          out_div_q[g] <= div_in;                        // see RL8 see RL9
      end
    end
  endgenerate

  // Apply sequencer: busy for a fixed time after a start write
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q          <= frac_pll_reconfig_pkg::IDLE;
      cnt_q            <= 4'h0;
      phase_pend_q     <= 1'b0;
      apply_strobe_out <= 1'b0;
      phase_strobe_out <= 1'b0;
      pll_setup_out    <= '0;
      out_dividers_out <= '0;
      phase_step_out   <= '0;
    end
    else
    begin
      apply_strobe_out <= 1'b0;
      phase_strobe_out <= 1'b0;
      if (wr_phase)
        phase_pend_q <= 1'b1;
      unique case (state_q)
        frac_pll_reconfig_pkg::IDLE:
          if (wr_apply)
          begin
            state_q <= frac_pll_reconfig_pkg::APPLY;     // see RL3 see RL24
            cnt_q   <= `APPLY_CYCLES;
          end
        frac_pll_reconfig_pkg::APPLY:
        begin
          pll_setup_out <= stage_q;
          for (int i = 0; i < `NUM_OUT_DIV; i++)
            out_dividers_out[i*18 +: 18] <= out_div_q[i];
          phase_step_out <= phase_q;
          if (cnt_q == `APPLY_CYCLES)
          begin
            apply_strobe_out <= 1'b1;
            phase_strobe_out <= phase_pend_q;
            phase_pend_q     <= 1'b0;
          end
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1)
            state_q <= frac_pll_reconfig_pkg::SHIFT;
        end
        frac_pll_reconfig_pkg::SHIFT:
          state_q <= frac_pll_reconfig_pkg::IDLE;       // see RL24
      endcase
    end
  end
endmodule : frac_pll_reconfig_regs
`default_nettype wire

// [rtl/frac_pll_reconfig_defines.svh]
// Behaviour
// RL1 - Mode register picks wait-request (0) or polling (1); held and readable.
// RL2 - Read-only status bit: 0 while reconfiguring, 1 when ready.
// RL3 - Any write to the start register launches the staged reconfiguration; in polling mode a start write accepted while busy is ignored.
// RL4 - Prescale divider: low count bits 7-0, high count bits 15-8.
// RL5 - Prescale bit 16 bypasses the divider.
// RL6 - Bit 17 of each divider selects odd or even division.
// RL7 - Feedback divider uses the same count, bypass and parity layout.
// RL8 - Output divider uses the same count, bypass and parity layout.
// RL9 - Output divider write bits 22-18 index which of eighteen dividers changes.
// RL10 - Bypass and parity bits are write-only; reads return them as zero.
// RL11 - Output divider settings read back at per-divider locations.
// RL12 - Phase shift register bits 15-0 hold the shift count.
// RL13 - Phase shift bits 20-16 select the divider to shift.
// RL14 - Phase shift bit 21 gives direction; 0 means negative.
// RL15 - Write-only 32-bit fractional feedback value for the modulator.
// RL16 - Effective feedback division is total ratio plus the fraction.
// RL17 - Readable 4-bit bandwidth code and 3-bit charge pump code.
// RL18 - Readable VCO post-divider bit: 0 divides by 2, 1 by 1.
// RL19 - Write-only 9-bit profile base location.
// RL20 - Master command is sampled on the first edge after wait-request falls.
// RL21 - Commands are ignored while wait-request is high.
// RL22 - Management reset returns all settings to initial values.
// RL23 - Output dividers 0-17 read at locations 0x0A to 0x1B.
// RL24 - After start, status shows busy until settings are applied.
`ifndef FRAC_PLL_RECONFIG_DEFINES_SVH
`define FRAC_PLL_RECONFIG_DEFINES_SVH
`define ADR_STYLE      6'h00
`define ADR_READY      6'h01
`define ADR_APPLY      6'h02
`define ADR_PRESCALE   6'h03
`define ADR_FEEDBACK   6'h04
`define ADR_OUTPUT     6'h05
`define ADR_PHASE      6'h06
`define ADR_FRACTION   6'h07
`define ADR_BANDWIDTH  6'h08
`define ADR_PUMP       6'h09
`define ADR_OUT_FIRST  6'h0A
`define ADR_OUT_LAST   6'h1B
`define ADR_HALVING    6'h1C
`define ADR_PROFILE    6'h1F
`define NUM_OUT_DIV    18
`define OUT_IDX_MAX    5'h11
`define APPLY_CYCLES   4'h8
`define DIV_RESET      18'h00101
`define FRAC_RESET     32'h00000000
`endif

// [rtl/frac_pll_reconfig_pkg.sv]
package frac_pll_reconfig_pkg;
  typedef struct packed {
    logic       odd_div;
    logic       bypass;
    logic [7:0] high_count;
    logic [7:0] low_count;
  } divider_t;
  typedef struct packed {
    logic       shift_direction;
    logic [4:0] counter_select;
    logic [15:0] shift_count;
  } phase_step_t;
  typedef struct packed {
    divider_t    prescale;
    divider_t    feedback;
    logic [31:0] feedback_fraction;
    logic [3:0]  loop_bandwidth_code;
    logic [2:0]  pump_current_code;
    logic        osc_halving_select;
    logic [8:0]  profile_base_location;
  } pll_setup_t;
  typedef enum logic [1:0] {IDLE, APPLY, SHIFT} apply_state_t;
endpackage : frac_pll_reconfig_pkg

// [test/frac_pll_reconfig_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "frac_pll_reconfig_defines.svh"
module frac_pll_reconfig_monitor
(
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic [5:0]  mgmt_address_in,
  input wire logic        mgmt_read_in,
  input wire logic        mgmt_write_in,
  input wire logic [31:0] mgmt_read_data_out,
  input wire logic        mgmt_waitrequest_out,
  input wire logic        apply_strobe_out,
  input wire logic        phase_strobe_out
);
  wire logic rd_ok = mgmt_read_in && !mgmt_waitrequest_out;
  wire logic go = mgmt_write_in && !mgmt_waitrequest_out && mgmt_address_in == `ADR_APPLY;
  wire logic rd_wo = rd_ok && (mgmt_address_in inside {`ADR_APPLY, `ADR_PHASE, `ADR_FRACTION});
  wire logic rd_div = rd_ok && (mgmt_address_in inside {`ADR_PRESCALE, `ADR_FEEDBACK}
                      || mgmt_address_in >= `ADR_OUT_FIRST && mgmt_address_in <= `ADR_OUT_LAST);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Busy stretch: ten cycles high, then low
  sequence s_busy;
    mgmt_waitrequest_out[*8] ##1 mgmt_waitrequest_out ##1 mgmt_waitrequest_out
      ##1 !mgmt_waitrequest_out;
  endsequence
  chk_idle_data_zero: assert property (!rd_ok |=> mgmt_read_data_out == 32'h0)
    else $error("read data not zero without accepted read");
  chk_wo_read_zero: assert property (rd_wo |=> mgmt_read_data_out == 32'h0)
    else $error("write-only register returned data");
  chk_div_bits_hidden: assert property (rd_div |=> mgmt_read_data_out[31:16] == 16'h0)
    else $error("divider upper bits visible");
  chk_start_pulse: assert property (go |=> ##1 apply_strobe_out)
    else $error("start write gave no apply pulse");
  chk_pulse_cause: assert property (apply_strobe_out |-> $past(go, 2))
    else $error("apply pulse without start write");
  chk_pulse_single: assert property (apply_strobe_out |=> !apply_strobe_out)
    else $error("apply pulse longer than one cycle");
  chk_phase_paired: assert property (phase_strobe_out |-> apply_strobe_out)
    else $error("phase pulse outside apply");
  chk_busy_window: assert property ($rose(mgmt_waitrequest_out) |-> s_busy)
    else $error("wait-request stretch has wrong length");
  chk_wait_cause: assert property ($rose(mgmt_waitrequest_out) |-> $past(go))
    else $error("wait-request raised without start write");
endmodule : frac_pll_reconfig_monitor
bind frac_pll_reconfig_regs frac_pll_reconfig_monitor u_frac_pll_reconfig_monitor
  (.clk_in(clk_in), .rst_b_in(rst_b_in), .mgmt_address_in(mgmt_address_in),
   .mgmt_read_in(mgmt_read_in), .mgmt_write_in(mgmt_write_in),
   .mgmt_read_data_out(mgmt_read_data_out), .mgmt_waitrequest_out(mgmt_waitrequest_out),
   .apply_strobe_out(apply_strobe_out), .phase_strobe_out(phase_strobe_out));
`default_nettype wire

// [test/mgmt_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mgmt_master_model
(
  input  wire logic        clk_in,
  input  wire logic        waitrequest_in,
  output var  logic [5:0]  address_out,
  output var  logic        read_out,
  output var  logic        write_out,
  output var  logic [31:0] write_data_out,
  output var  logic        hung_out
);
  initial
  begin
    {address_out, read_out, write_out, write_data_out, hung_out} = '0;
  end
  // Holds the command until an edge sees wait-request low
  task automatic access(input logic [5:0] a, input logic rd, input logic [31:0] d);
    int n;
    @(negedge clk_in);
    {address_out, read_out, write_out, write_data_out} = {a, rd, !rd, d};
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end while (waitrequest_in && n < 100);
    if (n >= 100) hung_out = 1'b1;
    // Release the strobes once the command was taken
    @(negedge clk_in);
    {read_out, write_out} = 2'b00;
  endtask : access
  task automatic idle;
    @(negedge clk_in);
    {read_out, write_out, write_data_out} = {2'b00, ~write_data_out};
  endtask : idle
endmodule : mgmt_master_model
`default_nettype wire

// [test/tb_frac_pll_reconfig_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "frac_pll_reconfig_defines.svh"
module tb_frac_pll_reconfig_regs;
  logic clk_in, rst_b_in, rd_in, wr_in, wait_out, app, phs, rd_seen, hung;
  logic [5:0] adr;
  logic [31:0] wd, rdat, d, c, p, f;
  logic [18*18-1:0] outs;
  frac_pll_reconfig_pkg::pll_setup_t setup;
  frac_pll_reconfig_pkg::phase_step_t step;
  frac_pll_reconfig_pkg::pll_setup_t  setup_seen;
  frac_pll_reconfig_pkg::phase_step_t step_seen;
  logic app_seen = 1'b0;
  logic phs_seen;
  logic [31:0] exp_q[$];
  logic [5:0] ra[4] = '{`ADR_STYLE, `ADR_BANDWIDTH, `ADR_PUMP, `ADR_HALVING};
  logic [31:0] rm[4] = '{32'h1, 32'hF, 32'h7, 32'h1};
  int bad_count, cmp_count, seed, n;
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  frac_pll_reconfig_regs u_frac_pll_reconfig_regs (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .mgmt_address_in(adr), .mgmt_read_in(rd_in), .mgmt_write_in(wr_in),
    .mgmt_write_data_in(wd), .mgmt_read_data_out(rdat), .mgmt_waitrequest_out(wait_out),
    .pll_setup_out(setup), .out_dividers_out(outs), .phase_step_out(step),
    .apply_strobe_out(app), .phase_strobe_out(phs));
  mgmt_master_model u_mgmt_master_model (.clk_in(clk_in), .waitrequest_in(wait_out),
    .address_out(adr), .read_out(rd_in), .write_out(wr_in), .write_data_out(wd),
    .hung_out(hung));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_mgmt_master_model.access(a, 1'b1, 32'h0);
  endtask : rd
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    u_mgmt_master_model.access(a, 1'b0, v);
  endtask : wr
  task automatic summarize;
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  always @(posedge clk_in) rd_seen <= rd_in && !wait_out;
  always @(negedge clk_in) if (rd_seen) check("read data", rdat, exp_q.pop_front());
  // Snapshot of the outputs while the one-cycle apply pulse stands
  always @(negedge clk_in)
    if (app)
    begin
      app_seen   <= 1'b1;
      phs_seen   <= phs;
      step_seen  <= step;
      setup_seen <= setup;
    end
  initial
  begin
    {rst_b_in, rd_seen, bad_count, cmp_count, seed} = {2'b00, 64'h0, 32'h43};
    repeat (16) @(negedge clk_in);
    rst_b_in = 1'b1;
    rd(`ADR_READY, 32'h1);
    rd(`ADR_PRESCALE, 32'h101);
    rd(`ADR_FEEDBACK, 32'h101);
    foreach (ra[i]) begin d = $random(seed); wr(ra[i], d); rd(ra[i], d & rm[i]); end
    rd(`ADR_APPLY, 32'h0);
    rd(`ADR_PHASE, 32'h0);
    rd(`ADR_FRACTION, 32'h0);
    rd(`ADR_PROFILE, 32'h0);
    d = {14'h0, 2'b11, 16'($random(seed))};
    wr(`ADR_PRESCALE, d);
    rd(`ADR_PRESCALE, {16'h0, d[15:0]});
    c = $random(seed);
    wr(`ADR_FEEDBACK, {14'h0, 2'b10, c[15:0]});
    rd(`ADR_FEEDBACK, {16'h0, c[15:0]});
    wr(`ADR_OUTPUT, {9'h0, 5'h11, 2'b11, c[15:0]});
    wr(`ADR_OUTPUT, {9'h0, 5'h12, 2'b00, ~c[15:0]});
    rd(`ADR_OUT_LAST, {16'h0, c[15:0]});
    rd(`ADR_OUT_FIRST, 32'h101);
    p = $random(seed);
    f = $random(seed);
    wr(`ADR_PHASE, p);
    wr(`ADR_FRACTION, f);
    wr(`ADR_STYLE, 32'h1);
    wr(`ADR_APPLY, 32'h0);
    rd(`ADR_READY, 32'h0);
    for (n = 0; n < 30 && !app_seen; n++) @(negedge clk_in);
    check("apply", 32'(app_seen), 32'h1);
    check("phase strobe", 32'(phs_seen), 32'h1);
    check("phase step", 32'(step_seen), {10'h0, p[21:0]});
    check("prescale", 32'(setup_seen.prescale), d & 32'h3FFFF);
    check("fraction", setup_seen.feedback_fraction, f);
    repeat (10) @(negedge clk_in);
    rd(`ADR_READY, 32'h1);
    wr(`ADR_STYLE, 32'h0);
    wr(`ADR_APPLY, 32'h1);
    rd(`ADR_READY, 32'h1);
    u_mgmt_master_model.idle();
    rst_b_in = 1'b0;
    @(negedge clk_in);
    rst_b_in = 1'b1;
    rd(`ADR_PRESCALE, 32'h101);
    rd(`ADR_STYLE, 32'h0);
    u_mgmt_master_model.idle();
    repeat (3) @(negedge clk_in);
    check("hang", 32'(hung), 32'h0);
    summarize();
  end
endmodule : tb_frac_pll_reconfig_regs
`default_nettype wire
